//--- logic/airs_map.vh
// Register map and field layout of the converter input and reference select block
// Assumes an 8-bit register port on the system clock
`ifndef AIRS_MAP_VH
`define AIRS_MAP_VH

// ****************************************
// Register offsets
// ****************************************
`define AIRS_OFS_CHAN      4'h0
`define AIRS_OFS_INCLK     4'h1
`define AIRS_OFS_REFAMP    4'h2
`define AIRS_OFS_BANDGAP   4'h3
`define AIRS_OFS_PINSEL_LO 4'h4
`define AIRS_OFS_PINSEL_HI 4'h5
`define AIRS_OFS_STATUS    4'h6

// ****************************************
// Field positions
// ****************************************
`define AIRS_SRC_HI        7
`define AIRS_SRC_LO        4
`define AIRS_CLK_HI        2
`define AIRS_CLK_LO        0
`define AIRS_AMP_EN        7
`define AIRS_AMP_IN        4
`define AIRS_REF_HI        3
`define AIRS_REF_LO        2
`define AIRS_GAIN_HI       1
`define AIRS_GAIN_LO       0
`define AIRS_BG_EN         0

// ****************************************
// Reset values and masks
// ****************************************
`define AIRS_RST_BYTE      8'h00
`define AIRS_RST_PINS      16'h0000
`define AIRS_INCLK_MASK    8'hf7
`define AIRS_REFAMP_MASK   8'h9f
`define AIRS_BANDGAP_MASK  8'h01
`define AIRS_CHAN_MASK     8'h0f

// ****************************************
// Input source kinds
// ****************************************
`define AIRS_KIND_EXT      3'h0
`define AIRS_KIND_AVDD     3'h1
`define AIRS_KIND_AVDD2    3'h2
`define AIRS_KIND_AVDD4    3'h3
`define AIRS_KIND_VR       3'h4
`define AIRS_KIND_VR2      3'h5
`define AIRS_KIND_VR4      3'h6
`define AIRS_KIND_GND      3'h7

// ****************************************
// Reference kinds
// ****************************************
`define AIRS_REFK_AVDD     2'h0
`define AIRS_REFK_PIN      2'h1
`define AIRS_REFK_AMP      2'h2

`endif

//--- logic/airs_clk_div.v
// Conversion clock divider: one-cycle enable pulse at the system clock over 2**sel
// Assumes sel comes from a register on the same clock
`include "airs_map.vh"

module airs_clk_div (
  input  wire       clk_sys,
  input  wire       rst_b,
  input  wire [2:0] sel,
  output reg        tick
);

  reg  [6:0] cnt_reg;
  reg  [6:0] cnt_next;
  reg  [6:0] limit;

  // ****************************************
  // Divider
  // ****************************************
  always @* begin
    limit    = 7'h7f >> (3'h7 - sel);
    cnt_next = (cnt_reg >= limit) ? 7'h00 : cnt_reg + 7'h01;
  end

  // Restart on overrun so a smaller divide never waits a full wrap
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      cnt_reg <= 7'h00;
      tick    <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      tick    <= (cnt_reg >= limit);
    end
  end

endmodule

//--- logic/airs_src_decode.v
// Input source decode: source code and channel to analog mux controls
// Pure combinational; inputs come from registers on the same clock
`include "airs_map.vh"

module airs_src_decode (
  input  wire [3:0]  src,
  input  wire [3:0]  chan,
  output reg  [2:0]  kind,
  output reg  [15:0] ext_onehot
);

  always @* begin
    case (src)
      4'h0, 4'h4, 4'hc, 4'hd, 4'he, 4'hf: kind = `AIRS_KIND_EXT;
      4'h1: kind = `AIRS_KIND_AVDD;
      4'h2: kind = `AIRS_KIND_AVDD2;
      4'h3: kind = `AIRS_KIND_AVDD4;
      4'h5: kind = `AIRS_KIND_VR;
      4'h6: kind = `AIRS_KIND_VR2;
      4'h7: kind = `AIRS_KIND_VR4;
      default: kind = `AIRS_KIND_GND;
    endcase
    // Internal source opens every external switch; never two sources shorted
    ext_onehot = (kind == `AIRS_KIND_EXT) ? (16'h0001 << chan) : 16'h0000;
  end

endmodule

//--- logic/airs_top.v
// Converter input, clock and reference select control, register port and analog controls
// Assumes a plain single-cycle register master on clk_sys; analog switches are static levels
//
// The register offsets and the plain strobed port are this design's own decisions.
`include "airs_map.vh"

module airs_top (
  input  wire        clk_sys,
  input  wire        rst_b,
  input  wire [3:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [7:0]  reg_rdata,
  input  wire [15:0] pin_pull_en,
  input  wire [15:0] pin_dir_out,
  output reg  [2:0]  input_kind,
  output reg  [15:0] analog_input_pin_sw,
  output wire        conv_clk_tick,
  output reg         ref_amp_enable,
  output reg         ref_amp_input_select,
  output reg         amp_reference_pin_sw,
  output reg  [1:0]  ref_amp_gain_select,
  output reg  [1:0]  reference_kind,
  output reg         ext_ref_pin_sw,
  output reg         bandgap_enable,
  output reg  [15:0] pin_digital_off,
  output reg  [15:0] pin_pull_eff,
  output reg  [15:0] pin_dir_eff
);

  // ****************************************
  // Registers
  // ****************************************
  reg  [3:0]  external_channel_select_reg;
  reg  [7:0]  adc_input_clock_select_reg;
  reg  [7:0]  adc_reference_amp_control_reg;
  reg  [7:0]  bandgap_enable_control_reg;
  reg  [7:0]  pin_function_select_low_reg;
  reg  [7:0]  pin_function_select_high_reg;
  reg  [7:0]  rdata_next;
  wire [2:0]  kind_next;
  wire [15:0] ext_next;
  wire [15:0] analog_pins;

  function [1:0] ref_kind;
    input [1:0] fld;
    begin
      ref_kind = fld[1] ? `AIRS_REFK_AMP : (fld[0] ? `AIRS_REFK_PIN : `AIRS_REFK_AVDD);
    end
  endfunction

  always @(posedge clk_sys) begin
    if (!rst_b) begin
      external_channel_select_reg   <= 4'h0;
      adc_input_clock_select_reg    <= `AIRS_RST_BYTE;
      adc_reference_amp_control_reg <= `AIRS_RST_BYTE;
      bandgap_enable_control_reg    <= `AIRS_RST_BYTE;
      pin_function_select_low_reg   <= `AIRS_RST_BYTE;
      pin_function_select_high_reg  <= `AIRS_RST_BYTE;
    end else if (reg_wr) begin
      case (reg_addr)
        `AIRS_OFS_CHAN:      external_channel_select_reg <= reg_wdata[3:0];
        `AIRS_OFS_INCLK:     adc_input_clock_select_reg <= reg_wdata & `AIRS_INCLK_MASK;
        `AIRS_OFS_REFAMP:    adc_reference_amp_control_reg <= reg_wdata & `AIRS_REFAMP_MASK;
        `AIRS_OFS_BANDGAP:   bandgap_enable_control_reg <= reg_wdata & `AIRS_BANDGAP_MASK;
        `AIRS_OFS_PINSEL_LO: pin_function_select_low_reg <= reg_wdata;
        `AIRS_OFS_PINSEL_HI: pin_function_select_high_reg <= reg_wdata;
        default: ;
      endcase
    end
  end

  // ****************************************
  // Read port
  // ****************************************
  always @* begin
    case (reg_addr)
      `AIRS_OFS_CHAN:      rdata_next = {4'h0, external_channel_select_reg};
      `AIRS_OFS_INCLK:     rdata_next = adc_input_clock_select_reg;
      `AIRS_OFS_REFAMP:    rdata_next = adc_reference_amp_control_reg;
      `AIRS_OFS_BANDGAP:   rdata_next = bandgap_enable_control_reg;
      `AIRS_OFS_PINSEL_LO: rdata_next = pin_function_select_low_reg;
      `AIRS_OFS_PINSEL_HI: rdata_next = pin_function_select_high_reg;
      `AIRS_OFS_STATUS:    rdata_next = {3'h0, amp_reference_pin_sw, ext_ref_pin_sw, input_kind};
      default:             rdata_next = 8'h00;
    endcase
  end

  // Data stands only in the cycle after the read strobe
  always @(posedge clk_sys) begin
    if (!rst_b)
      reg_rdata <= 8'h00;
    else
      reg_rdata <= reg_rd ? rdata_next : 8'h00;
  end

  // ****************************************
  // Input mux and clock
  // ****************************************
  airs_src_decode u_dec (
    .src        (adc_input_clock_select_reg[`AIRS_SRC_HI:`AIRS_SRC_LO]),
    .chan       (external_channel_select_reg),
    .kind       (kind_next),
    .ext_onehot (ext_next)
  );

  airs_clk_div u_div (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .sel     (adc_input_clock_select_reg[`AIRS_CLK_HI:`AIRS_CLK_LO]),
    .tick    (conv_clk_tick)
  );

  // ****************************************
  // Analog controls
  // ****************************************
  assign analog_pins = {pin_function_select_high_reg, pin_function_select_low_reg};

  // One cycle behind the register, so controls change after each write
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      input_kind           <= `AIRS_KIND_EXT;
      analog_input_pin_sw  <= 16'h0000;
      ref_amp_enable       <= 1'b0;
      ref_amp_input_select <= 1'b0;
      amp_reference_pin_sw <= 1'b0;
      ref_amp_gain_select  <= 2'h0;
      reference_kind       <= `AIRS_REFK_AVDD;
      ext_ref_pin_sw       <= 1'b0;
      bandgap_enable       <= 1'b0;
      pin_digital_off      <= `AIRS_RST_PINS;
      pin_pull_eff         <= `AIRS_RST_PINS;
      pin_dir_eff          <= `AIRS_RST_PINS;
    end else begin
      input_kind           <= kind_next;
      analog_input_pin_sw  <= ext_next;
      ref_amp_enable       <= adc_reference_amp_control_reg[`AIRS_AMP_EN];
      ref_amp_input_select <= adc_reference_amp_control_reg[`AIRS_AMP_IN];
      // Pin switch only closes while the pin is the amplifier input
      amp_reference_pin_sw <= ~adc_reference_amp_control_reg[`AIRS_AMP_IN];
      ref_amp_gain_select  <= adc_reference_amp_control_reg[`AIRS_GAIN_HI:`AIRS_GAIN_LO];
      reference_kind       <= ref_kind(adc_reference_amp_control_reg[`AIRS_REF_HI:`AIRS_REF_LO]);
      ext_ref_pin_sw       <= (ref_kind(adc_reference_amp_control_reg[`AIRS_REF_HI:`AIRS_REF_LO])
                               == `AIRS_REFK_PIN);
      // No interlock: software enables the bandgap and waits before use
      bandgap_enable       <= bandgap_enable_control_reg[`AIRS_BG_EN];
      pin_digital_off      <= analog_pins;
      pin_pull_eff         <= pin_pull_en & ~analog_pins;
      pin_dir_eff          <= pin_dir_out & ~analog_pins;
    end
  end

endmodule

//--- tb/airs_top_properties.sv
// Checker for the converter input, clock and reference select block
// Assumes binding onto airs_top; sees only its ports
module airs_top_props (
  input wire        clk_sys,
  input wire        rst_b,
  input wire [3:0]  reg_addr,
  input wire [7:0]  reg_wdata,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [7:0]  reg_rdata,
  input wire [15:0] pin_pull_en,
  input wire [15:0] pin_dir_out,
  input wire [2:0]  input_kind,
  input wire [15:0] analog_input_pin_sw,
  input wire        ref_amp_enable,
  input wire        ref_amp_input_select,
  input wire        amp_reference_pin_sw,
  input wire [1:0]  reference_kind,
  input wire        ext_ref_pin_sw,
  input wire [15:0] pin_digital_off,
  input wire [15:0] pin_pull_eff,
  input wire [15:0] pin_dir_eff
);
  timeunit 1ns;
  timeprecision 1ps;
  reg [7:0] wd_q1;
  reg [7:0] wd_q2;
  function automatic [2:0] kind_of(input [3:0] s);
    kind_of = s[3] ? (s[2] ? 3'h0 : 3'h7) : (s[1:0] == 2'h0) ? 3'h0 : {1'b0, s[1:0]} + (s[2] ? 3'h3 : 3'h0);
  endfunction
  // Write data delayed to line up with the two-edge output latency
  always @(posedge clk_sys) begin
    wd_q1 <= reg_wdata;
    wd_q2 <= wd_q1;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  internal_src_open_a: assert property (input_kind != 3'h0 |-> analog_input_pin_sw == 16'h0000)
    else $error("channel switch closed on internal source");
  src_decode_a: assert property (reg_wr && reg_addr == 4'h1 |-> ##2 input_kind == kind_of(wd_q2[7:4]))
    else $error("source kind wrong after write");
  ref_decode_a: assert property (reg_wr && reg_addr == 4'h2 |-> ##2 ref_amp_enable == wd_q2[7] &&
    ref_amp_input_select == wd_q2[4] && reference_kind == (wd_q2[3] ? 2'h2 : {1'b0, wd_q2[2]}))
    else $error("reference decode wrong after write");
  amp_pin_off_a: assert property ($past(rst_b) |-> amp_reference_pin_sw != ref_amp_input_select)
    else $error("amplifier pin switch not opposite to input select");
  ext_ref_only_a: assert property (ext_ref_pin_sw == (reference_kind == 2'h1))
    else $error("external reference switch mismatch");
  pull_off_a: assert property ($past(rst_b) |-> pin_pull_eff == ($past(pin_pull_en) & ~pin_digital_off))
    else $error("pull-high left on analog pin");
  dir_off_a: assert property ($past(rst_b) |-> pin_dir_eff == ($past(pin_dir_out) & ~pin_digital_off))
    else $error("direction not overridden on analog pin");
  pad_bits_a: assert property ($past(reg_rd) |-> !(($past(reg_addr) == 4'h1 && reg_rdata[3]) ||
    ($past(reg_addr) == 4'h2 && reg_rdata[6:5] != 2'h0) || ($past(reg_addr) == 4'h3 && reg_rdata[7:1] != 7'h00)))
    else $error("unimplemented bit reads as one");
  digital_off_a: assert property (reg_wr && reg_addr == 4'h4 |-> ##2 pin_digital_off[7:0] == wd_q2)
    else $error("digital function not released on analog pin");
  cover property (input_kind == 3'h7);
  cover property (ext_ref_pin_sw);
  cover property (reg_wr && reg_addr == 4'h5);
endmodule

bind airs_top airs_top_props i_airs_top_props (.clk_sys, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .pin_pull_en, .pin_dir_out, .input_kind, .analog_input_pin_sw, .ref_amp_enable,
  .ref_amp_input_select, .amp_reference_pin_sw, .reference_kind, .ext_ref_pin_sw, .pin_digital_off,
  .pin_pull_eff, .pin_dir_eff);

//--- tb/airs_top_tb.sv
// Self-checking bench for the converter input, clock and reference select block
// Assumes airs_top with its checker bound; bench is the only register master
module airs_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys, rst_b, reg_wr, reg_rd;
  logic [3:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, rd_val;
  logic [15:0] pin_pull_en, pin_dir_out, analog_input_pin_sw, pin_digital_off, pin_pull_eff, pin_dir_eff;
  logic [2:0]  input_kind, k;
  logic [1:0]  ref_amp_gain_select, reference_kind;
  logic        conv_clk_tick, ref_amp_enable, ref_amp_input_select, amp_reference_pin_sw, ext_ref_pin_sw;
  logic        bandgap_enable;
  int          num_errors = 0, checks = 0, cycles = 0, n;
  airs_top i_airs_top (.clk_sys, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .pin_pull_en,
    .pin_dir_out, .input_kind, .analog_input_pin_sw, .conv_clk_tick, .ref_amp_enable, .ref_amp_input_select,
    .amp_reference_pin_sw, .ref_amp_gain_select, .reference_kind, .ext_ref_pin_sw, .bandgap_enable,
    .pin_digital_off, .pin_pull_eff, .pin_dir_eff);
  // ****************************************
  // Clock, timeout and bus tasks
  // ****************************************
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors = num_errors + 1;
      wrap_up;
    end
  end
  // Ends two edges after the write edge so decoded outputs have landed
  task automatic wr(input [3:0] a, input [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask
  task automatic rd(input [3:0] a);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks = checks + 1;
    if (got !== exp) begin
      num_errors = num_errors + 1;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rst_b = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    pin_pull_en = 16'hffff;
    pin_dir_out = 16'ha5a5;
    repeat (6) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    chk(analog_input_pin_sw, 16'h0001);
    for (int i = 1; i < 4; i++) begin
      rd(i[3:0]);
      chk(rd_val, 16'h0000);
    end
    // Bandgap on and settled before anything picks it as amplifier input
    wr(4'h3, 8'hff);
    repeat (50) @(posedge clk_sys);
    rd(4'h3);
    chk(rd_val, 16'h0001);
    chk(bandgap_enable, 16'h0001);
    wr(4'h1, 8'hff);
    rd(4'h1);
    chk(rd_val, 16'h00f7);
    wr(4'h2, 8'hff);
    rd(4'h2);
    chk(rd_val, 16'h009f);
    wr(4'hf, 8'hff);
    rd(4'hf);
    chk(rd_val, 16'h0000);
    // Channel follows the loop index so the ignored field is never zero
    for (int i = 0; i < 16; i++) begin
      wr(4'h0, i[7:0]);
      wr(4'h1, {i[3:0], 4'h0});
      k = i[3] ? (i[2] ? 3'h0 : 3'h7) : (i[1:0] == 2'h0) ? 3'h0 : {1'b0, i[1:0]} + (i[2] ? 3'h3 : 3'h0);
      chk(input_kind, k);
      chk(analog_input_pin_sw, (k == 3'h0) ? 16'h0001 << i : 16'h0000);
      rd(4'h6);
      chk(rd_val, {13'h0000, k});
      wr(4'h1, 8'hc0);
      chk(analog_input_pin_sw, 16'h0001 << i);
    end
    // Shared pins released before the reference pins are used
    wr(4'h5, 8'h00);
    for (int v = 0; v < 32; v++) begin
      wr(4'h2, {v[0], 2'h0, v[4:0]});
      rd(4'h6);
      chk(rd_val, {11'h000, !v[4], v[3:2] == 2'h1, 3'h0});
      chk(ref_amp_enable, v[0]);
      chk(ref_amp_input_select, v[4]);
      chk(amp_reference_pin_sw, !v[4]);
      chk(ref_amp_gain_select, v[1:0]);
      chk(reference_kind, v[3] ? 2'h2 : {1'b0, v[2]});
      chk(ext_ref_pin_sw, v[3:2] == 2'h1);
    end
    wr(4'h4, 8'h5a);
    wr(4'h5, 8'hc3);
    chk(pin_digital_off, 16'hc35a);
    chk(pin_pull_eff, 16'h3ca5);
    chk(pin_dir_eff, 16'h24a5);
    for (int f = 0; f < 8; f++) begin
      wr(4'h1, f[7:0]);
      repeat (300) @(posedge clk_sys);
      n = 0;
      repeat (256) begin
        @(posedge clk_sys);
        #1 n = n + conv_clk_tick;
      end
      chk(n[15:0], 16'h0100 >> f);
    end
    wrap_up;
  end
endmodule
